/* rtl/drive_monitor_map.svh */
`ifndef DRIVE_MONITOR_MAP_SVH
`define DRIVE_MONITOR_MAP_SVH

// register indices; byte address is four times the index
`define IDX_REGEN_LOAD_RATE       20'h0E00B
`define IDX_POWERUP_TIME_TOTAL    20'h0E00E
`define IDX_INDEX_PULSE_COUNT     20'h0E017
`define IDX_INDEX_PULSE_ONEWAY    20'h0E018
`define IDX_STATUS_WORD_ONE       20'h0E02A
`define IDX_CONTROL               20'h0E100
`define IDX_SPEED_THRESHOLD       20'h0E101
`define IDX_IRQ_STATUS            20'h0E102
`define IDX_IRQ_MASK              20'h0E103

// control register fields and reset values
`define CTRL_INDEX_COUNT_EN_BIT   0
`define CTRL_RESET                32'h0000_0000
`define SPEED_THRESHOLD_RESET     16'h0000
`define IRQ_MASK_RESET            3'h0

// interrupt status bits
`define IRQ_INDEX_PULSE_BIT       0
`define IRQ_COUNT_CLEARED_BIT     1
`define IRQ_REGEN_WINDOW_BIT      2
`define IRQ_WIDTH                 3

// timing
`define CLK_PERIOD_NS             10
`define TENTH_S_NS                100000000
`define TENTH_S_CYCLES            (`TENTH_S_NS / `CLK_PERIOD_NS)
`define REGEN_WINDOW_S            10
`define REGEN_WINDOW_TICKS        (`REGEN_WINDOW_S * 10)

`endif

/* rtl/drive_monitor_pkg.sv */
package drive_monitor_pkg;

   // register selected by a bus address
   typedef enum logic [3:0] {
      SEL_REGEN,
      SEL_POWERUP,
      SEL_INDEX,
      SEL_ONEWAY,
      SEL_STATUS1,
      SEL_CONTROL,
      SEL_THRESHOLD,
      SEL_IRQ_STATUS,
      SEL_IRQ_MASK,
      SEL_NONE
   } reg_sel_e;

   typedef logic [1:0] axi_resp_t;

   localparam axi_resp_t RESP_OKAY   = 2'h0;
   localparam axi_resp_t RESP_SLVERR = 2'h2;

endpackage

/* rtl/drive_monitor_tick.sv */
`timescale 1ns/1ps

// one-cycle pulse every CYCLES clocks
module drive_monitor_tick #(
   parameter int unsigned CYCLES = 10000000
) (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   output logic      o_tick
);
   localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;
   wire           at_last = (cnt_q == LAST);

   // free running divider from the system clock
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         cnt_q  <= at_last ? '0 : cnt_q + 1'b1;
         o_tick <= at_last;
      end
   end
endmodule

/* rtl/drive_monitor_status_bank.sv */
// What this block does
// - regen load rate in percent over last 10 s, accumulating only above threshold.
// - running time counts in 0.1 s units once main voltage is established.
// - running time is held as one 32-bit value.
// - up to one hour drift allowed after many rapid power cycles.
// - absolute index counter counts every index pulse, either direction.
// - both index counters zero at power-up and on up plus down keys.
// - second index counter counts one direction only.
// - index pulses counted only while index count enable equals one.
// - status word bits 0 to 13 show the listed drive flags.
// - speed mode: bit 6 set when speed command exceeds threshold.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "drive_monitor_map.svh"

module drive_monitor_status_bank
   import drive_monitor_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `TENTH_S_CYCLES,
   parameter int unsigned ADDR_W      = 20
) (
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   // drive signals
   input  wire logic              i_mains_ok,
   input  wire logic              i_regen_active,
   input  wire logic [7:0]        i_regen_pct,
   input  wire logic              i_index_pulse,
   input  wire logic              i_index_fwd,
   input  wire logic              i_init_done,
   input  wire logic              i_servo_on_req,
   input  wire logic              i_dyn_brake,
   input  wire logic              i_motor_dir,
   input  wire logic              i_speed_loop_mode,
   input  wire logic              i_speed_mode,
   input  wire logic [15:0]       i_speed_cmd,
   input  wire logic              i_max_torque,
   input  wire logic              i_full_closed_loop,
   input  wire logic              i_aux_connector_5v,
   input  wire logic              i_key_mode,
   input  wire logic              i_key_up,
   input  wire logic              i_key_down,
   input  wire logic              i_key_set,
   output logic                   o_irq
);
   localparam logic [15:0] WINDOW_TICKS = 16'(`REGEN_WINDOW_TICKS);
   localparam logic [6:0]  WINDOW_LAST  = 7'(`REGEN_WINDOW_TICKS - 1);

   // register decode on word index; misaligned or unknown goes to none
   function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] idx;
      idx = {2'b00, a[ADDR_W-1:2]};
      if (a[1:0] != 2'b00)                          return SEL_NONE;
      if (idx == ADDR_W'(`IDX_REGEN_LOAD_RATE))     return SEL_REGEN;
      if (idx == ADDR_W'(`IDX_POWERUP_TIME_TOTAL))  return SEL_POWERUP;
      if (idx == ADDR_W'(`IDX_INDEX_PULSE_COUNT))   return SEL_INDEX;
      if (idx == ADDR_W'(`IDX_INDEX_PULSE_ONEWAY))  return SEL_ONEWAY;
      if (idx == ADDR_W'(`IDX_STATUS_WORD_ONE))     return SEL_STATUS1;
      if (idx == ADDR_W'(`IDX_CONTROL))             return SEL_CONTROL;
      if (idx == ADDR_W'(`IDX_SPEED_THRESHOLD))     return SEL_THRESHOLD;
      if (idx == ADDR_W'(`IDX_IRQ_STATUS))          return SEL_IRQ_STATUS;
      if (idx == ADDR_W'(`IDX_IRQ_MASK))            return SEL_IRQ_MASK;
      return SEL_NONE;
   endfunction

   // byte-lane merge for writable words
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // 0.1 s time base
   logic tick;
   drive_monitor_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .o_tick    (tick)
   );

   // ---------------- bus slave state ----------------
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic [31:0]       ctrl_q;
   logic [15:0]       thr_q;
   logic [2:0]        irq_stat_q;
   logic [2:0]        irq_mask_q;

   wire       aw_take   = i_awvalid & o_awready;
   wire       w_take    = i_wvalid & o_wready;
   wire       b_done    = o_bvalid & i_bready;
   wire       ar_take   = i_arvalid & o_arready;
   wire       r_done    = o_rvalid & i_rready;
   // both halves captured, response not yet raised
   wire       do_write  = ~o_awready & ~o_wready & ~o_bvalid;
   wire reg_sel_e wsel  = decode(awaddr_q);
   wire reg_sel_e rsel  = decode(i_araddr);
   wire       wr_ctrl   = do_write & (wsel == SEL_CONTROL);
   wire       wr_thr    = do_write & (wsel == SEL_THRESHOLD);
   wire       wr_istat  = do_write & (wsel == SEL_IRQ_STATUS);
   wire       wr_imask  = do_write & (wsel == SEL_IRQ_MASK);
   wire [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire       index_en  = ctrl_q[`CTRL_INDEX_COUNT_EN_BIT];

   // ---------------- regenerative load ----------------
   logic [15:0] regen_sum_q;
   logic [6:0]  regen_tick_q;
   logic [15:0] regen_rate_q;
   wire  [15:0] regen_sample = i_regen_active ? {8'h00, i_regen_pct} : 16'h0000;
   wire  [15:0] regen_sum_d  = regen_sum_q + regen_sample;
   wire         win_end      = tick & (regen_tick_q == WINDOW_LAST);

   // window sum; rate refreshed only when a 10 s window closes
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         regen_sum_q  <= 16'h0000;
         regen_tick_q <= 7'h00;
         regen_rate_q <= 16'h0000;
      end else if (tick) begin
         regen_tick_q <= win_end ? 7'h00 : regen_tick_q + 7'h01;
         regen_sum_q  <= win_end ? 16'h0000 : regen_sum_d;
         if (win_end) begin
            regen_rate_q <= regen_sum_d / WINDOW_TICKS;
         end
      end
   end

   // ---------------- power-up time ----------------
   // sub-tick remainder is lost at each power cut, hence the drift
   logic [31:0] powerup_q;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         powerup_q <= 32'h0000_0000;
      end else if (tick & i_mains_ok) begin
         powerup_q <= powerup_q + 32'h0000_0001;
      end
   end

   // ---------------- index pulse counters ----------------
   logic        combo_q;
   logic [15:0] index_q;
   logic [15:0] oneway_q;
   wire         key_combo = i_key_up & i_key_down;
   wire         key_clear = key_combo & ~combo_q;
   wire         count_abs = i_index_pulse & index_en;
   wire         count_one = count_abs & i_index_fwd;
   wire  [15:0] index_base  = key_clear ? 16'h0000 : index_q;
   wire  [15:0] oneway_base = key_clear ? 16'h0000 : oneway_q;

   // clear and an enabled pulse in one cycle leave index_q at one, and oneway_q at one only for a forward pulse
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         combo_q  <= 1'b0;
         index_q  <= 16'h0000;
         oneway_q <= 16'h0000;
      end else begin
         combo_q  <= key_combo;
         index_q  <= index_base + {15'h0000, count_abs};
         oneway_q <= oneway_base + {15'h0000, count_one};
      end
   end

   // ---------------- status word one ----------------
   logic [15:0] status1_q;
   wire         speed_over = i_speed_mode & (i_speed_cmd > thr_q);
   wire  [15:0] status1_d  = {2'b00, i_key_set, i_key_down, i_key_up, i_key_mode,
                              i_aux_connector_5v, i_full_closed_loop,
                              i_max_torque, speed_over, i_speed_loop_mode, i_motor_dir,
                              i_dyn_brake, i_servo_on_req, i_init_done, i_mains_ok};

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         status1_q <= 16'h0000;
      end else begin
         status1_q <= status1_d;
      end
   end

   // ---------------- interrupts ----------------
   wire [2:0] irq_event  = {win_end, key_clear, count_abs};
   wire [2:0] irq_clear  = wr_istat ? (wdata_q[2:0] & wmask[2:0]) : 3'h0;
   // a new event wins over a write-one-to-clear in the same cycle
   wire [2:0] irq_stat_d = (irq_stat_q & ~irq_clear) | irq_event;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         irq_stat_q <= 3'h0;
         o_irq      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         o_irq      <= |(irq_stat_d & irq_mask_q);
      end
   end

   // ---------------- writable registers ----------------
   wire [31:0] ctrl_w  = merge(ctrl_q, wdata_q, wstrb_q);
   wire [31:0] thr_w   = merge({16'h0000, thr_q}, wdata_q, wstrb_q);
   wire [31:0] imask_w = merge({29'h0, irq_mask_q}, wdata_q, wstrb_q);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl_q     <= `CTRL_RESET;
         thr_q      <= `SPEED_THRESHOLD_RESET;
         irq_mask_q <= `IRQ_MASK_RESET;
      end else begin
         if (wr_ctrl)  ctrl_q     <= {31'h0, ctrl_w[0]};
         if (wr_thr)   thr_q      <= thr_w[15:0];
         if (wr_imask) irq_mask_q <= imask_w[2:0];
      end
   end

   // ---------------- write channel ----------------
   // monitored words are read-only; writes to them are accepted and dropped
   wire axi_resp_t wresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_take) begin
            awaddr_q  <= i_awaddr;
            o_awready <= 1'b0;
         end else if (b_done) begin
            o_awready <= 1'b1;
         end
         if (w_take) begin
            wdata_q  <= i_wdata;
            wstrb_q  <= i_wstrb;
            o_wready <= 1'b0;
         end else if (b_done) begin
            o_wready <= 1'b1;
         end
         if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wresp;
         end else if (b_done) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // ---------------- read channel ----------------
   // read mux has no side effects on any counter or flag
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (rsel)
         SEL_REGEN:      rmux = {16'h0000, regen_rate_q};
         SEL_POWERUP:    rmux = powerup_q;
         SEL_INDEX:      rmux = {16'h0000, index_q};
         SEL_ONEWAY:     rmux = {16'h0000, oneway_q};
         SEL_STATUS1:    rmux = {16'h0000, status1_q};
         SEL_CONTROL:    rmux = ctrl_q;
         SEL_THRESHOLD:  rmux = {16'h0000, thr_q};
         SEL_IRQ_STATUS: rmux = {29'h0, irq_stat_q};
         SEL_IRQ_MASK:   rmux = {29'h0, irq_mask_q};
         SEL_NONE:       rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= RESP_OKAY;
      end else if (ar_take) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= rmux;
         o_rresp   <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (r_done) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
      end
   end

   // ---------------- assertions ----------------
   sequence both_halves_s;
      !o_awready && !o_wready && !o_bvalid;
   endsequence

   sequence resp_raised_s;
      o_bvalid && !o_awready && !o_wready;
   endsequence

   regen_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !win_end |=> $stable(regen_rate_q))
      else $error("regen rate changed outside window end");

   time_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (tick && i_mains_ok) |=> powerup_q == $past(powerup_q) + 32'h0000_0001)
      else $error("power-up time missed a tick");

   time_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!tick || !i_mains_ok) |=> $stable(powerup_q))
      else $error("power-up time moved without a tick");

   index_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_index_pulse && index_en && !key_clear) |=> index_q == $past(index_q) + 16'h0001)
      else $error("index pulse not counted");

   index_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (key_clear && !i_index_pulse) |=> (index_q == 16'h0000) && (oneway_q == 16'h0000))
      else $error("index counters not cleared by keys");

   oneway_dir_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!key_clear && !(i_index_pulse && i_index_fwd)) |=> $stable(oneway_q))
      else $error("one-way counter moved on reverse pulse");

   index_enable_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!index_en && !key_clear) |=> $stable(index_q) && $stable(oneway_q))
      else $error("index counted while disabled");

   status_flags_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ##1 status1_q[3:0] == $past({i_dyn_brake, i_servo_on_req, i_init_done, i_mains_ok}))
      else $error("status low flags wrong");

   status_keys_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ##1 (status1_q[15:10] == {2'b00, $past({i_key_set, i_key_down, i_key_up, i_key_mode})}))
      else $error("status key bits wrong");

   speed_over_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_speed_mode && (i_speed_cmd > thr_q)) |=> status1_q[6])
      else $error("speed rotation flag not set");

   read_value_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ar_take && rsel == SEL_POWERUP) |=> o_rvalid && o_rdata == $past(powerup_q))
      else $error("read returned wrong power-up time");

   write_resp_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      both_halves_s |=> resp_raised_s)
      else $error("write response not raised");

endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "drive_monitor_map.svh"

module tb
   import drive_monitor_pkg::*;
;
   logic        i_clk;
   logic        i_sys_rst;
   logic [19:0] i_awaddr;
   logic        i_awvalid;
   logic        o_awready;
   logic [31:0] i_wdata;
   logic [3:0]  i_wstrb;
   logic        i_wvalid;
   logic        o_wready;
   logic [1:0]  o_bresp;
   logic        o_bvalid;
   logic        i_bready;
   logic [19:0] i_araddr;
   logic        i_arvalid;
   logic        o_arready;
   logic [31:0] o_rdata;
   logic [1:0]  o_rresp;
   logic        o_rvalid;
   logic        i_rready;
   logic        i_regen_active;
   logic [7:0]  i_regen_pct;
   logic        i_index_pulse;
   logic        i_index_fwd;
   logic        i_speed_mode;
   logic [15:0] i_speed_cmd;
   logic        o_irq;
   logic [13:0] sw;
   logic [31:0] rdat;
   logic [1:0]  resp;
   int          n_fail;
   int          n_compared;
   int          cycles;

   // short tick so a 10 s window is 1000 cycles
   drive_monitor_status_bank #(.TICK_CYCLES(10), .ADDR_W(20)) DUT (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
      .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .i_mains_ok(sw[0]), .i_regen_active(i_regen_active), .i_regen_pct(i_regen_pct),
      .i_index_pulse(i_index_pulse), .i_index_fwd(i_index_fwd),
      .i_init_done(sw[1]), .i_servo_on_req(sw[2]), .i_dyn_brake(sw[3]),
      .i_motor_dir(sw[4]), .i_speed_loop_mode(sw[5]), .i_speed_mode(i_speed_mode),
      .i_speed_cmd(i_speed_cmd), .i_max_torque(sw[7]), .i_full_closed_loop(sw[8]),
      .i_aux_connector_5v(sw[9]), .i_key_mode(sw[10]), .i_key_up(sw[11]),
      .i_key_down(sw[12]), .i_key_set(sw[13]), .o_irq(o_irq)
   );

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // hang guard; the whole sequence needs well under 6000 cycles
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // index to byte address; values sampled pre-update right after the edge
   task automatic wr(input logic [19:0] idx, input logic [31:0] d, output logic [1:0] r);
      i_awaddr  <= {idx[17:0], 2'b00};
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      i_bready  <= 1'b1;
      forever begin
         @(posedge i_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         // bready stays high; dropping it here would clash with the next call's raise
         if (o_bvalid && i_bready) begin
            r = o_bresp;
            break;
         end
      end
   endtask

   task automatic rd(input logic [19:0] idx, output logic [31:0] d, output logic [1:0] r);
      i_araddr  <= {idx[17:0], 2'b00};
      i_arvalid <= 1'b1;
      i_rready  <= 1'b1;
      forever begin
         @(posedge i_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid && i_rready) begin
            d = o_rdata;
            r = o_rresp;
            break;
         end
      end
   endtask

   task automatic expect_rd(input string name, input logic [19:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      check(name, d, exp);
      check({name, " resp"}, {30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic wr_ok(input logic [19:0] idx, input logic [31:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic pulse(input logic fwd);
      i_index_fwd   <= fwd;
      i_index_pulse <= 1'b1;
      @(posedge i_clk);
      i_index_pulse <= 1'b0;
      @(posedge i_clk);
   endtask

   initial begin
      n_fail = 0;
      n_compared = 0;
      cycles = 0;
      i_sys_rst = 1'b1;
      i_awaddr = 20'h0;
      i_awvalid = 1'b0;
      i_wdata = 32'h0;
      i_wstrb = 4'hF;
      i_wvalid = 1'b0;
      i_bready = 1'b0;
      i_araddr = 20'h0;
      i_arvalid = 1'b0;
      i_rready = 1'b0;
      i_regen_active = 1'b1;
      i_regen_pct = 8'h28;
      i_index_pulse = 1'b0;
      i_index_fwd = 1'b0;
      i_speed_mode = 1'b0;
      i_speed_cmd = 16'h0000;
      sw = 14'h0000;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      expect_rd("control", `IDX_CONTROL, 32'h0);
      expect_rd("threshold", `IDX_SPEED_THRESHOLD, 32'h0);
      expect_rd("irq mask", `IDX_IRQ_MASK, 32'h0);
      expect_rd("time idle", `IDX_POWERUP_TIME_TOTAL, 32'h0);
      rd(20'h0E050, rdat, resp);
      check("unmapped data", rdat, 32'h0);
      check("unmapped resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(20'h0E050, 32'hFFFFFFFF, resp);
      check("unmapped wr resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      // steady 40 percent while braking, then none while below threshold
      repeat (1100) @(posedge i_clk);
      expect_rd("regen 40", `IDX_REGEN_LOAD_RATE, 32'h28);
      i_regen_active <= 1'b0;
      repeat (2100) @(posedge i_clk);
      expect_rd("regen gated", `IDX_REGEN_LOAD_RATE, 32'h0);
      // 50 cycles of mains hold exactly five ticks whatever the phase
      sw[0] <= 1'b1;
      repeat (50) @(posedge i_clk);
      sw[0] <= 1'b0;
      repeat (3) @(posedge i_clk);
      expect_rd("time", `IDX_POWERUP_TIME_TOTAL, 32'h5);
      wr_ok(`IDX_POWERUP_TIME_TOTAL, 32'hFFFFFFFF);
      expect_rd("time ro", `IDX_POWERUP_TIME_TOTAL, 32'h5);
      // walking one through every flag except the speed compare
      for (int i = 0; i < 14; i++) begin
         if (i == 6) continue;
         sw <= 14'h1 << i;
         repeat (3) @(posedge i_clk);
         expect_rd("status flag", `IDX_STATUS_WORD_ONE, 32'h1 << i);
      end
      sw <= 14'h0000;
      wr_ok(`IDX_SPEED_THRESHOLD, 32'h0100);
      i_speed_mode <= 1'b1;
      i_speed_cmd  <= 16'h0101;
      repeat (3) @(posedge i_clk);
      expect_rd("speed above", `IDX_STATUS_WORD_ONE, 32'h40);
      i_speed_cmd <= 16'h0100;
      repeat (3) @(posedge i_clk);
      expect_rd("speed equal", `IDX_STATUS_WORD_ONE, 32'h0);
      i_speed_cmd  <= 16'h0101;
      i_speed_mode <= 1'b0;
      repeat (3) @(posedge i_clk);
      expect_rd("speed off mode", `IDX_STATUS_WORD_ONE, 32'h0);
      // only the low byte lane is strobed, the high byte must keep its old value
      i_wstrb <= 4'h1;
      wr_ok(`IDX_SPEED_THRESHOLD, 32'h0000_FFEE);
      i_wstrb <= 4'hF;
      expect_rd("threshold strobe", `IDX_SPEED_THRESHOLD, 32'h01EE);
      // counting disabled ignores pulses
      pulse(1'b1);
      pulse(1'b0);
      expect_rd("index off", `IDX_INDEX_PULSE_COUNT, 32'h0);
      wr_ok(`IDX_CONTROL, 32'h1);
      pulse(1'b1);
      pulse(1'b1);
      pulse(1'b0);
      pulse(1'b1);
      pulse(1'b0);
      expect_rd("index abs", `IDX_INDEX_PULSE_COUNT, 32'h5);
      expect_rd("index abs again", `IDX_INDEX_PULSE_COUNT, 32'h5);
      expect_rd("index oneway", `IDX_INDEX_PULSE_ONEWAY, 32'h3);
      // interrupt: masked, unmasked, then write-one clear
      repeat (3) @(posedge i_clk);
      check("irq masked", {31'h0, o_irq}, 32'h0);
      wr_ok(`IDX_IRQ_MASK, 32'h1);
      repeat (3) @(posedge i_clk);
      check("irq raised", {31'h0, o_irq}, 32'h1);
      wr_ok(`IDX_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge i_clk);
      check("irq cleared", {31'h0, o_irq}, 32'h0);
      rd(`IDX_IRQ_STATUS, rdat, resp);
      check("irq bit0", rdat & 32'h1, 32'h0);
      // up and down pressed together zero both counters
      sw <= 14'h1800;
      repeat (3) @(posedge i_clk);
      sw <= 14'h0000;
      repeat (3) @(posedge i_clk);
      expect_rd("abs cleared", `IDX_INDEX_PULSE_COUNT, 32'h0);
      expect_rd("oneway cleared", `IDX_INDEX_PULSE_ONEWAY, 32'h0);
      rd(`IDX_IRQ_STATUS, rdat, resp);
      check("clear event", rdat & 32'h2, 32'h2);
      pulse(1'b1);
      expect_rd("count after clear", `IDX_INDEX_PULSE_ONEWAY, 32'h1);
      print_verdict();
   end
endmodule
